// [design/sac_conv_ctrl.sv]
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - enable low means shutdown, no conversions
// - completion writes 10-bit code to result bytes
// - justify select: low ten or high ten
// - unused result bits read zero
// - binary search gives linear unsigned code
// - eight-bit mode: 8 msbs in high byte
// - eight-bit mode ignores justify select
// - eight-bit conversion two sar clocks shorter
// - 13 sar clocks, or 11 in eight-bit
// - sar clock divided by divider field plus one
// - start source picks one of six triggers
// - software busy write starts conversion
// - pin rising edge starts conversion
// - timers 2/3 use width-selected overflow
// - busy high for whole conversion
// - busy falling sets done, requests interrupt; a shutdown abort drops busy without setting done
// - results valid whenever done reads one
// - delayed mode tracks three sar clocks first
// - immediate mode converts at trigger
// - internal sources track whenever not converting
// - pin source: track if delayed or pin low
module sac_conv_ctrl (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire sac_pkg::sac_tmr_ovf_t tmr_ovf,
  input  wire logic                  external_convert_start,
  input  wire logic                  cmp_above,
  output logic                       converter_power,
  output logic                       track_enable,
  output logic [9:0]                 dac_code,
  output logic                       conversion_irq
);

  sac_pkg::sac_st_t s_q;
  sac_pkg::sac_st_t s_d;
  logic             acc;
  logic             tick;
  logic             trig;
  logic             sw_go;
  logic             clr_done;
  logic             ext_edge;
  logic [3:0]       bi;
  logic [3:0]       nb;
  logic [3:0]       total;
  logic [31:0]      rd_val;

  assign tick     = s_q.enable && (s_q.div == 5'h00);
  assign ext_edge = s_q.ext_s2 && !s_q.ext_s3;
  assign acc      = hsel && htrans[1] && hready;
  assign nb       = s_q.cbe ? sac_pkg::BITS_8 : sac_pkg::BITS_10;
  assign total    = s_q.cbe ? sac_pkg::CONV_CLKS_8 : sac_pkg::CONV_CLKS_10;
  assign bi       = 4'(sac_pkg::BITS_10 - s_q.cnt);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (!s_q.hok) begin
      rd_val = 32'h0000_0000;
    end else if (s_q.hadr == sac_pkg::CTRL_OFS) begin
      rd_val[sac_pkg::EN_B]                       = s_q.enable;
      rd_val[sac_pkg::DTM_B]                      = s_q.dtm;
      rd_val[sac_pkg::SRC_LSB +: 3]               = s_q.src;
      rd_val[sac_pkg::BUSY_B]                     = s_q.state != sac_pkg::ST_IDLE;
      rd_val[sac_pkg::DONE_B]                     = s_q.done;
      rd_val[sac_pkg::IE_B]                       = s_q.ie;
    end else if (s_q.hadr == sac_pkg::CFG_OFS) begin
      rd_val[sac_pkg::GAIN_B]                     = s_q.gain;
      rd_val[sac_pkg::EB_B]                       = s_q.eb;
      rd_val[sac_pkg::LJ_B]                       = s_q.lj;
      rd_val[sac_pkg::SC_LSB +: 5]                = s_q.sc;
    end else if (s_q.hadr == sac_pkg::RESH_OFS) begin
      rd_val[7:0]                                 = s_q.res_hi;
    end else if (s_q.hadr == sac_pkg::RESL_OFS) begin
      rd_val[7:0]                                 = s_q.res_lo;
    end else if (s_q.hadr == sac_pkg::TMR_OFS) begin
      rd_val[sac_pkg::T2W_B]                      = s_q.t2_16;
      rd_val[sac_pkg::T3W_B]                      = s_q.t3_16;
    end
  end

  always_comb begin
    s_d      = s_q;
    sw_go    = 1'b0;
    clr_done = 1'b0;
    trig     = 1'b0;

    // bus: writes are zero-wait, reads take one wait state
    s_d.hwr    = acc && hwrite;
    s_d.hrd    = acc && !hwrite;
    s_d.hready = !(acc && !hwrite);
    if (acc) begin
      s_d.hadr = haddr[7:0];
      s_d.hok  = (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
    end
    if (s_q.hrd) begin
      s_d.hrdata = rd_val;
    end
    if (s_q.hwr && s_q.hok) begin
      if (s_q.hadr == sac_pkg::CTRL_OFS) begin
        s_d.enable = hwdata[sac_pkg::EN_B];
        s_d.dtm    = hwdata[sac_pkg::DTM_B];
        s_d.src    = hwdata[sac_pkg::SRC_LSB +: 3];
        s_d.ie     = hwdata[sac_pkg::IE_B];
        sw_go      = hwdata[sac_pkg::BUSY_B];
        clr_done   = !hwdata[sac_pkg::DONE_B];
      end else if (s_q.hadr == sac_pkg::CFG_OFS) begin
        s_d.gain = hwdata[sac_pkg::GAIN_B];
        s_d.eb   = hwdata[sac_pkg::EB_B];
        s_d.lj   = hwdata[sac_pkg::LJ_B];
        s_d.sc   = hwdata[sac_pkg::SC_LSB +: 5];
      end else if (s_q.hadr == sac_pkg::TMR_OFS) begin
        s_d.t2_16 = hwdata[sac_pkg::T2W_B];
        s_d.t3_16 = hwdata[sac_pkg::T3W_B];
      end
    end
    if (clr_done) begin
      s_d.done = 1'b0;
    end

    s_d.ext_s1 = external_convert_start;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;

    case (s_q.src)
      sac_pkg::SRC_SW:  trig = sw_go;
      sac_pkg::SRC_T0:  trig = tmr_ovf.t0;
      sac_pkg::SRC_T2:  trig = s_q.t2_16 ? tmr_ovf.t2_hi : tmr_ovf.t2_lo;
      sac_pkg::SRC_T1:  trig = tmr_ovf.t1;
      sac_pkg::SRC_EXT: trig = ext_edge;
      sac_pkg::SRC_T3:  trig = s_q.t3_16 ? tmr_ovf.t3_hi : tmr_ovf.t3_lo;
      default:          trig = 1'b0;
    endcase

    if (!s_q.enable) begin
      // shutdown aborts any conversion without flagging completion
      s_d.state = sac_pkg::ST_IDLE;
      s_d.div   = s_q.sc;
      s_d.cnt   = 4'h0;
    end else begin
      s_d.div = tick ? s_q.sc : 5'(s_q.div - 5'h01);
      case (s_q.state)
        sac_pkg::ST_IDLE: begin
          if (trig) begin
            s_d.cnt = 4'h0;
            s_d.cbe = s_q.eb;
            if (s_q.dtm) begin
              s_d.state = sac_pkg::ST_DELAY;
            end else begin
              s_d.state = sac_pkg::ST_CONV;
              s_d.sar   = sac_pkg::SAR_MSB;
            end
          end
        end
        sac_pkg::ST_DELAY: begin
          if (tick) begin
            if (s_q.cnt == 4'(sac_pkg::DELAY_CLKS - 4'h1)) begin
              s_d.state = sac_pkg::ST_CONV;
              s_d.cnt   = 4'h0;
              s_d.sar   = sac_pkg::SAR_MSB;
            end else begin
              s_d.cnt = 4'(s_q.cnt + 4'h1);
            end
          end
        end
        sac_pkg::ST_CONV: begin
          if (tick) begin
            // one bit per sar clock, msb first
            if (s_q.cnt >= 4'h1 && s_q.cnt <= nb) begin
              if (!cmp_above) begin
                s_d.sar[bi] = 1'b0;
              end
              if (s_q.cnt < nb) begin
                s_d.sar[4'(bi - 4'h1)] = 1'b1;
              end
            end
            if (s_q.cnt == 4'(total - 4'h1)) begin
              s_d.state = sac_pkg::ST_IDLE;
              s_d.done  = 1'b1;
              if (s_q.cbe) begin
                s_d.res_hi = s_q.sar[9:2];
                s_d.res_lo = 8'h00;
              end else if (s_q.lj) begin
                s_d.res_hi = s_q.sar[9:2];
                s_d.res_lo = {s_q.sar[1:0], 6'h00};
              end else begin
                s_d.res_hi = {6'h00, s_q.sar[9:8]};
                s_d.res_lo = s_q.sar[7:0];
              end
            end else begin
              s_d.cnt = 4'(s_q.cnt + 4'h1);
            end
          end
        end
        default: s_d.state = sac_pkg::ST_IDLE;
      endcase
    end

    // pin source in immediate mode tracks only while the pin is low
    s_d.track = s_d.enable && (s_d.state == sac_pkg::ST_DELAY ||
                (s_d.state == sac_pkg::ST_IDLE && (s_d.src != sac_pkg::SRC_EXT ||
                 s_d.dtm || !s_q.ext_s2)));
    s_d.irq = s_d.done && s_d.ie;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q        <= '0;
      s_q.state  <= sac_pkg::ST_IDLE;
      s_q.sc     <= sac_pkg::SC_RST;
      s_q.div    <= sac_pkg::SC_RST;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout       = s_q.hready;
  assign hresp           = s_q.hwr && 1'b0;
  assign hrdata          = s_q.hrdata;
  assign converter_power = s_q.enable;
  assign track_enable    = s_q.track;
  assign dac_code        = s_q.sar;
  assign conversion_irq  = s_q.irq;

  // helper: sar clocks counted over each conversion
  logic       busy;
  logic [4:0] h_cnt;
  logic [4:0] h_exp;

  assign busy = s_q.state != sac_pkg::ST_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      h_cnt <= 5'h00;
      h_exp <= 5'h00;
    end else if (!busy) begin
      h_cnt <= 5'h00;
      h_exp <= 5'({1'b0, s_q.eb ? sac_pkg::CONV_CLKS_8 : sac_pkg::CONV_CLKS_10} +
                  (s_q.dtm ? {1'b0, sac_pkg::DELAY_CLKS} : 5'h00));
    end else if (tick) begin
      h_cnt <= 5'(h_cnt + 5'h01);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_off;
    !s_q.enable |=> !busy ##1 !busy;
  endproperty
  a_off: assert property (p_off) else $error("busy while disabled");

  property p_len;
    $fell(busy) && $past(s_q.enable) |-> h_cnt == h_exp;
  endproperty
  a_len: assert property (p_len) else $error("wrong conversion length");

  property p_done;
    $fell(busy) && $past(s_q.enable) |-> s_q.done ##1 s_q.irq == (s_q.done && s_q.ie);
  endproperty
  a_done: assert property (p_done) else $error("done not set at end");

  property p_sticky;
    s_q.done && !clr_done |=> s_q.done;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done cleared by hardware");

  property p_right;
    $fell(busy) && $past(s_q.enable) && !s_q.cbe && !$past(s_q.lj) |->
      s_q.res_hi[7:2] == 6'h00 && {s_q.res_hi[1:0], s_q.res_lo} == s_q.sar;
  endproperty
  a_right: assert property (p_right) else $error("right justify wrong");

  property p_eight;
    $fell(busy) && $past(s_q.enable) && s_q.cbe |->
      s_q.res_lo == 8'h00 && s_q.res_hi == s_q.sar[9:2];
  endproperty
  a_eight: assert property (p_eight) else $error("eight-bit result wrong");

  property p_sw;
    s_q.enable && !busy && s_q.src == sac_pkg::SRC_SW && sw_go |=> busy [*2];
  endproperty
  a_sw: assert property (p_sw) else $error("software start missed");

  property p_ext;
    s_q.enable && !busy && s_q.src == sac_pkg::SRC_EXT && ext_edge |=> busy;
  endproperty
  a_ext: assert property (p_ext) else $error("pin start missed");

  property p_imm;
    s_q.enable && !busy && !s_q.dtm && trig |=> s_q.state == sac_pkg::ST_CONV && !s_q.track;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate start late");

  property p_trk;
    s_q.enable && !busy && s_q.src != sac_pkg::SRC_EXT |-> s_q.track;
  endproperty
  a_trk: assert property (p_trk) else $error("not tracking when idle");

  property p_left;
    $fell(busy) && $past(s_q.enable) && !s_q.cbe && $past(s_q.lj) |->
      {s_q.res_hi, s_q.res_lo} == {s_q.sar, 6'h00};
  endproperty
  a_left: assert property (p_left) else $error("left justify wrong");

  property p_dly;
    s_q.enable && s_d.enable && !busy && s_q.dtm && trig |=> s_q.state == sac_pkg::ST_DELAY;
  endproperty
  a_dly: assert property (p_dly) else $error("delayed start skipped");

  property p_hold;
    busy && s_q.enable && !tick |=> busy;
  endproperty
  a_hold: assert property (p_hold) else $error("busy ended between sar clocks");

  property p_cnt;
    s_q.state == sac_pkg::ST_CONV |-> s_q.cnt < total;
  endproperty
  a_cnt: assert property (p_cnt) else $error("conversion overran");

  property p_dcnt;
    s_q.state == sac_pkg::ST_DELAY |-> s_q.cnt < sac_pkg::DELAY_CLKS;
  endproperty
  a_dcnt: assert property (p_dcnt) else $error("tracking delay overran");

  property p_div;
    s_q.enable && !tick |=> s_q.div == 5'($past(s_q.div) - 5'h01);
  endproperty
  a_div: assert property (p_div) else $error("divider not counting down");

  property p_shut;
    !s_q.enable && !s_d.enable |=> !s_q.track && !busy;
  endproperty
  a_shut: assert property (p_shut) else $error("active while shut down");

  // track flop lags the synced pin by one stage
  property p_pin_trk;
    s_q.enable && !busy && s_q.src == sac_pkg::SRC_EXT && !s_q.dtm |->
      s_q.track == !s_q.ext_s3;
  endproperty
  a_pin_trk: assert property (p_pin_trk) else $error("pin tracking wrong");

  property p_res;
    $changed({s_q.res_hi, s_q.res_lo}) |-> $fell(busy);
  endproperty
  a_res: assert property (p_res) else $error("result changed outside completion");

  property p_rise;
    $rose(s_q.done) |-> $fell(busy);
  endproperty
  a_rise: assert property (p_rise) else $error("done set without completion");

  property p_bad;
    s_q.enable && !busy && s_q.src > sac_pkg::SRC_T3 |=> !busy;
  endproperty
  a_bad: assert property (p_bad) else $error("reserved source started");

  property p_start;
    s_q.enable && !busy && !s_q.dtm && trig |=> dac_code == sac_pkg::SAR_MSB;
  endproperty
  a_start: assert property (p_start) else $error("search not from midscale");

  property p_lsb;
    s_q.state == sac_pkg::ST_CONV && s_q.cbe |-> s_q.sar[1:0] == 2'b00;
  endproperty
  a_lsb: assert property (p_lsb) else $error("eight-bit touched low bits");

endmodule // sac_conv_ctrl

// [design/sac_pkg.sv]
package sac_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS  = 8'h04;
  localparam logic [7:0] RESH_OFS = 8'h08;
  localparam logic [7:0] RESL_OFS = 8'h0C;
  localparam logic [7:0] TMR_OFS  = 8'h10;

  // control register fields
  localparam int EN_B    = 0;
  localparam int DTM_B   = 1;
  localparam int SRC_LSB = 2;
  localparam int BUSY_B  = 5;
  localparam int DONE_B  = 6;
  localparam int IE_B    = 7;

  // configuration register fields
  localparam int GAIN_B = 0;
  localparam int EB_B   = 1;
  localparam int LJ_B   = 2;
  localparam int SC_LSB = 3;

  // timer width register fields
  localparam int T2W_B = 0;
  localparam int T3W_B = 1;

  localparam logic [4:0] SC_RST = 5'h1F;

  // start source encodings
  localparam logic [2:0] SRC_SW  = 3'h0;
  localparam logic [2:0] SRC_T0  = 3'h1;
  localparam logic [2:0] SRC_T2  = 3'h2;
  localparam logic [2:0] SRC_T1  = 3'h3;
  localparam logic [2:0] SRC_EXT = 3'h4;
  localparam logic [2:0] SRC_T3  = 3'h5;

  // timing in sar clocks, bit counts and sar start code
  localparam logic [3:0] CONV_CLKS_10 = 4'hD;
  localparam logic [3:0] CONV_CLKS_8  = CONV_CLKS_10 - 4'h2;
  localparam logic [3:0] DELAY_CLKS   = 4'h3;
  localparam logic [3:0] BITS_10      = 4'hA;
  localparam logic [3:0] BITS_8       = 4'h8;
  localparam logic [9:0] SAR_MSB      = 10'h200;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} sac_state_t;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2_lo;
    logic t2_hi;
    logic t3_lo;
    logic t3_hi;
  } sac_tmr_ovf_t;

  typedef struct packed {
    sac_state_t  state;
    logic        enable;
    logic        dtm;
    logic [2:0]  src;
    logic        ie;
    logic        done;
    logic        lj;
    logic        eb;
    logic        gain;
    logic [4:0]  sc;
    logic        t2_16;
    logic        t3_16;
    logic [4:0]  div;
    logic [3:0]  cnt;
    logic        cbe;
    logic [9:0]  sar;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic        track;
    logic        irq;
    logic        hwr;
    logic        hrd;
    logic        hok;
    logic [7:0]  hadr;
    logic        hready;
    logic [31:0] hrdata;
  } sac_st_t;

endpackage

// [sim/sac_conv_ctrl_tb_top.sv]
`timescale 1ns/1ns
`define CHECK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module sac_conv_ctrl_tb_top;
  logic                  hclk;
  logic                  hresetn;
  logic                  hsel;
  logic                  hwrite;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr;
  logic [31:0]           hwdata;
  logic                  hreadyout;
  logic                  hresp;
  logic [31:0]           hrdata;
  logic [31:0]           rd;
  logic                  ext_pin;
  logic                  cpwr;
  logic                  trk;
  logic                  irq;
  logic [9:0]            dac;
  logic [9:0]            vin;
  logic [1:0]            tw;
  sac_pkg::sac_tmr_ovf_t tmr;
  int                    errors;
  int                    n_tests;

  // ideal comparator: settles within the cycle after each trial code
  wire logic cmp = (vin >= dac);

  sac_conv_ctrl DUT (
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hreadyout),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .hrdata                 (hrdata),
    .tmr_ovf                (tmr),
    .external_convert_start (ext_pin),
    .cmp_above              (cmp),
    .converter_power        (cpwr),
    .track_enable           (trk),
    .dac_code               (dac),
    .conversion_irq         (irq)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task print_verdict;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 99);
    if (k >= 99) begin
      errors++;
      $display("[FAIL] %0t bus hang", $time);
      print_verdict;
    end
  endtask

  // single word transfer; entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [23:0] hi = 24'h0);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {hi, a};
    hsize  <= 3'h2;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdb(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task pulse(input sac_pkg::sac_tmr_ovf_t p);
    tmr <= p;
    @(posedge hclk);
    tmr <= '0;
  endtask

  function logic [31:0] cw(input logic [2:0] s, input logic d, input logic b, input logic f);
    return {24'h0, 1'b1, f, b, s, d, 1'b1};
  endfunction

  function logic [15:0] fmt(input logic [9:0] v, input logic lj, input logic eb);
    if (eb)
      return {v[9:2], 8'h00};
    if (lj)
      return {v, 6'h00};
    return {6'h00, v};
  endfunction

  task conv(input logic [2:0] s, input logic dtm, input logic eb, input logic lj,
            input logic [9:0] v, input logic [4:0] dv);
    sac_pkg::sac_tmr_ovf_t ok;
    logic [15:0]           e;
    int                    c;
    int                    nt;
    vin <= v;
    ok  = '0;
    case (s)
      sac_pkg::SRC_T0: ok.t0 = 1'b1;
      sac_pkg::SRC_T1: ok.t1 = 1'b1;
      sac_pkg::SRC_T2: if (tw[0]) ok.t2_hi = 1'b1; else ok.t2_lo = 1'b1;
      sac_pkg::SRC_T3: if (tw[1]) ok.t3_hi = 1'b1; else ok.t3_lo = 1'b1;
      default: ok = '0;
    endcase
    wr(sac_pkg::CFG_OFS, {24'h0, dv, lj, eb, 1'b0});
    wr(sac_pkg::CTRL_OFS, cw(s, dtm, 1'b0, 1'b0));
    pulse(~ok);
    tick(3);
    rdb(sac_pkg::CTRL_OFS);
    `CHECK(rd[5], 1'b0)
    `CHECK(trk, 1'b1)
    if (s == sac_pkg::SRC_SW)
      wr(sac_pkg::CTRL_OFS, cw(s, dtm, 1'b1, 1'b0));
    else if (s == sac_pkg::SRC_EXT)
      ext_pin <= 1'b1; // pin reserved for the start input
    else
      pulse(ok);
    c = 0;
    while (irq !== 1'b1 && c < 400) begin
      @(posedge hclk);
      c++;
      if (c == 5)
        `CHECK(trk, dtm)
    end
    if (c >= 400) begin
      errors++;
      $display("[FAIL] %0t conversion hang", $time);
      print_verdict;
    end
    `CHECK(dac, eb ? {v[9:2], 2'b00} : v)
    nt = (eb ? 11 : 13) + (dtm ? 3 : 0);
    // first tick may be partial, pin path adds sync delay
    `CHECK(c > (nt - 1) * (dv + 1) && c <= nt * (dv + 1) + 4, 1'b1)
    e = fmt(eb ? {v[9:2], 2'b00} : v, lj, eb);
    rdb(sac_pkg::CTRL_OFS);
    `CHECK(rd, cw(s, dtm, 1'b0, 1'b1))
    rdb(sac_pkg::RESH_OFS);
    `CHECK(rd, {24'h0, e[15:8]})
    rdb(sac_pkg::RESL_OFS);
    `CHECK(rd, {24'h0, e[7:0]})
    if (s == sac_pkg::SRC_EXT && !dtm)
      `CHECK(trk, 1'b0)
    ext_pin <= 1'b0;
    wr(sac_pkg::CTRL_OFS, cw(s, dtm, 1'b0, 1'b1));
    tick(4);
    `CHECK(irq, 1'b1)
    `CHECK(trk, 1'b1)
    wr(sac_pkg::CTRL_OFS, cw(s, dtm, 1'b0, 1'b0));
    tick(2);
    `CHECK(irq, 1'b0)
  endtask

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    htrans  = 2'h0;
    hsize   = 3'h2;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    ext_pin = 1'b0;
    vin     = 10'h0;
    tw      = 2'h0;
    tmr     = '0;
    errors  = 0;
    n_tests = 0;
    void'($urandom(32'h6A8F));
    tick(3);
    `CHECK(cpwr, 1'b0)
    `CHECK(irq, 1'b0)
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHECK(hresp, 1'b0)
    rdb(sac_pkg::CFG_OFS);
    `CHECK(rd, 32'h000000F8)
    rdb(sac_pkg::RESH_OFS);
    `CHECK(rd, 32'h0)
    wr(8'h14, 32'hFF);
    rdb(8'h14);
    `CHECK(rd, 32'h0)
    bus(1'b0, sac_pkg::CFG_OFS, 32'h0, 24'h1);
    `CHECK(rd, 32'h0)
    // disabled: a software start must not run
    wr(sac_pkg::CTRL_OFS, 32'h20);
    tick(3);
    rdb(sac_pkg::CTRL_OFS);
    `CHECK(rd, 32'h0)
    conv(sac_pkg::SRC_SW, 1'b0, 1'b0, 1'b1, 10'h3FF, 5'h3);
    conv(sac_pkg::SRC_SW, 1'b1, 1'b0, 1'b0, 10'h000, 5'h4);
    conv(sac_pkg::SRC_EXT, 1'b0, 1'b1, 1'b1, 10'h2C5, 5'h3);
    for (int i = 0; i < 18; i++) begin
      tw = 2'($urandom_range(3));
      wr(sac_pkg::TMR_OFS, {30'h0, tw});
      conv(i < 6 ? 3'(i) : 3'($urandom_range(5)), 1'($urandom), 1'($urandom), 1'($urandom),
           10'($urandom), 5'($urandom_range(7, 3)));
    end
    // reserved source code: no trigger of any kind may start
    wr(sac_pkg::CTRL_OFS, cw(3'h6, 1'b0, 1'b0, 1'b0));
    wr(sac_pkg::CTRL_OFS, cw(3'h6, 1'b0, 1'b1, 1'b0));
    pulse('1);
    ext_pin <= 1'b1;
    tick(4);
    rdb(sac_pkg::CTRL_OFS);
    `CHECK(rd[5], 1'b0)
    ext_pin <= 1'b0;
    // abort mid-conversion by clearing enable; source must be set first
    wr(sac_pkg::CTRL_OFS, cw(sac_pkg::SRC_SW, 1'b0, 1'b0, 1'b0));
    wr(sac_pkg::CTRL_OFS, cw(sac_pkg::SRC_SW, 1'b0, 1'b1, 1'b0));
    tick(8);
    rdb(sac_pkg::CTRL_OFS);
    `CHECK(rd[5], 1'b1)
    wr(sac_pkg::CTRL_OFS, 32'h0);
    tick(150);
    `CHECK(irq, 1'b0)
    `CHECK(cpwr, 1'b0)
    rdb(sac_pkg::CTRL_OFS);
    `CHECK(rd[6:5], 2'b00)
    print_verdict;
  end
endmodule // sac_conv_ctrl_tb_top
